// >>> hw/gidc_regs.v
// global identification and control register bank on classic wishbone
// assumes a wishbone master on clk_i and a datapath that takes
// datapath_reset_o as its reset and reports interrupt_active_i
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "gidc_map.vh"

module gidc_regs #(
    parameter RMII_PRESENT = 1'b1,
    parameter MII_PRESENT = 1'b1,
    parameter PHY_PRESENT = 1'b0,
    parameter [2:0] SILICON_REVISION = 3'h0,
    parameter [2:0] PORT_COUNT_MINUS_ONE = 3'h0,
    parameter LIU_PRESENT = 1'b0,
    parameter FRAMER_PRESENT = 1'b0,
    parameter ENCAP_PRESENT = 1'b1,
    parameter IMUX_PRESENT = 1'b1,
    parameter [1:0] REF_CLK_DIV = 2'h1
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire mii_mode_i,
    input wire interrupt_active_i,
    output reg reference_clock_o,
    output reg irq_n_o,
    output reg irq_n_oe_o,
    output reg datapath_reset_o,
    output reg reference_clock_output_off,
    output reg interrupt_pin_idle_mode
);

// ==========================================================
// soft reset timing
localparam SRST_CYCLES =
    (`GIDC_SRST_MIN_NS + `GIDC_CLK_PERIOD_NS - 1) / `GIDC_CLK_PERIOD_NS;

// ==========================================================
// identity values
wire [7:0] id_low;
wire [7:0] id_high;
assign id_low = {2'h0,
    RMII_PRESENT[0],
    MII_PRESENT[0],
    PHY_PRESENT[0],
    SILICON_REVISION};
assign id_high = {PORT_COUNT_MINUS_ONE,
    LIU_PRESENT[0],
    FRAMER_PRESENT[0],
    1'b0,
    ENCAP_PRESENT[0],
    IMUX_PRESENT[0]};

// ==========================================================
// wishbone slave
reg soft_reset;
wire access;
wire wr_ctl;
reg [7:0] rd_byte;
assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wr_ctl = access & wb_we_i & wb_sel_i[0] &
    (wb_adr_i[3:2] == `GIDC_IDX_CONTROL) & (wb_adr_i[1:0] == 2'h0);

always @* begin
    case (wb_adr_i[3:2])
        `GIDC_IDX_ID_LOW: rd_byte = id_low;
        `GIDC_IDX_ID_HIGH: rd_byte = id_high;
        `GIDC_IDX_CONTROL: rd_byte = {5'h00, reference_clock_output_off,
            interrupt_pin_idle_mode, soft_reset};
        default: rd_byte = 8'h00;
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
    end else begin
        wb_ack_o <= access;
        if (access && !wb_we_i)
            wb_dat_o <= {24'h000000, rd_byte};
    end
end

// ==========================================================
// control register
always @(posedge clk_i) begin
    if (rst_i) begin
        soft_reset <= 1'b0;
        reference_clock_output_off <= 1'b0;
        interrupt_pin_idle_mode <= 1'b0;
    end else if (wr_ctl) begin
        soft_reset <= wb_dat_i[`GIDC_CTL_SRST_BIT];
        if (wb_dat_i[`GIDC_CTL_SRST_BIT] || soft_reset) begin
            reference_clock_output_off <= 1'b0;
            interrupt_pin_idle_mode <= 1'b0;
        end else begin
            reference_clock_output_off <= wb_dat_i[`GIDC_CTL_REFOFF_BIT];
            interrupt_pin_idle_mode <= wb_dat_i[`GIDC_CTL_INTERRUPT_PIN_IDLE_MODE_BIT];
        end
    end else if (soft_reset) begin
        reference_clock_output_off <= 1'b0;
        interrupt_pin_idle_mode <= 1'b0;
    end
end

// ==========================================================
// datapath reset, stretched to the least hold time
reg [3:0] srst_cnt;
always @(posedge clk_i) begin
    if (rst_i) begin
        srst_cnt <= 4'h0;
        datapath_reset_o <= 1'b0;
    end else begin
        if (soft_reset)
            srst_cnt <= SRST_CYCLES[3:0];
        else if (srst_cnt != 4'h0)
            srst_cnt <= srst_cnt - 4'h1;
        datapath_reset_o <= soft_reset | (srst_cnt != 4'h0);
    end
end

// ==========================================================
// reference clock output: divide by REF_CLK_DIV+1 per half period,
// mii mode runs at half the rmii rate
reg [2:0] ref_cnt;
wire [2:0] ref_half;
assign ref_half = mii_mode_i ? {REF_CLK_DIV, 1'b1} : {1'b0, REF_CLK_DIV};
always @(posedge clk_i) begin
    if (rst_i || datapath_reset_o) begin
        ref_cnt <= 3'h0;
        reference_clock_o <= 1'b0;
    end else if (reference_clock_output_off) begin
        ref_cnt <= 3'h0;
        reference_clock_o <= 1'b0;
    end else if (ref_cnt >= ref_half) begin
        ref_cnt <= 3'h0;
        reference_clock_o <= ~reference_clock_o;
    end else begin
        ref_cnt <= ref_cnt + 3'h1;
    end
end

// ==========================================================
// interrupt pin drive
always @(posedge clk_i) begin
    if (rst_i) begin
        irq_n_o <= 1'b1;
        irq_n_oe_o <= 1'b1;
    end else if (interrupt_active_i) begin
        irq_n_o <= 1'b0;
        irq_n_oe_o <= 1'b1;
    end else begin
        irq_n_o <= 1'b1;
        irq_n_oe_o <= ~interrupt_pin_idle_mode;
    end
end

endmodule // gidc_regs

// >>> hw/gidc_map.vh
// register map constants for the global id and control register bank
// assumes inclusion by the design file only
`ifndef GIDC_MAP_VH
`define GIDC_MAP_VH

// register indices (byte address is four times the index)
`define GIDC_IDX_ID_LOW 2'h0
`define GIDC_IDX_ID_HIGH 2'h1
`define GIDC_IDX_CONTROL 2'h2

// identity low fields
`define GIDC_IDL_RMII_BIT 5
`define GIDC_IDL_MII_BIT 4
`define GIDC_IDL_PHY_BIT 3
`define GIDC_IDL_REV_MSB 2

// identity high fields
`define GIDC_IDH_PORTS_MSB 7
`define GIDC_IDH_PORTS_LSB 5
`define GIDC_IDH_LIU_BIT 4
`define GIDC_IDH_FRAMER_BIT 3
`define GIDC_IDH_ENCAP_BIT 1
`define GIDC_IDH_IMUX_BIT 0

// control fields and reset value
`define GIDC_CTL_REFOFF_BIT 2
`define GIDC_CTL_INTERRUPT_PIN_IDLE_MODE_BIT 1
`define GIDC_CTL_SRST_BIT 0
`define GIDC_CTL_RESET 3'h0

// least soft reset hold time
`define GIDC_SRST_MIN_NS 100
`define GIDC_CLK_PERIOD_NS 40

`endif

// >>> testbench/gidc_regs_assertions.sv
// checker for the id and control bank pins and bus
// assumes a bind into gidc_regs, one clock domain
`timescale 1ns/1ns
module gidc_regs_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire mii_mode_i,
    input wire interrupt_active_i,
    input wire reference_clock_o,
    input wire irq_n_o,
    input wire irq_n_oe_o,
    input wire datapath_reset_o,
    input wire reference_clock_output_off,
    input wire interrupt_pin_idle_mode
);
// ====
// pin and bus timing
default clocking cb @(posedge clk_i);
endclocking
default disable iff (rst_i);
sequence rmii_run;
    (!reference_clock_output_off && !datapath_reset_o && !mii_mode_i)[*8];
endsequence
ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
ack_reply_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("no ack");
irq_low_a: assert property (
    interrupt_active_i |=> !irq_n_o && irq_n_oe_o) else $error("irq not low");
irq_high_a: assert property (
    (!interrupt_active_i && !interrupt_pin_idle_mode)[*2]
    |-> irq_n_o && irq_n_oe_o) else $error("idle irq not high");
irq_float_a: assert property (
    (!interrupt_active_i && interrupt_pin_idle_mode)[*2]
    |-> !irq_n_oe_o) else $error("idle irq driven");
clk_off_a: assert property (
    reference_clock_output_off[*2] |-> !reference_clock_o)
    else $error("ref clock not held low");
clk_run_a: assert property (
    rmii_run |-> reference_clock_o != $past(reference_clock_o, 2))
    else $error("ref clock not running");
soft_rst_a: assert property (
    datapath_reset_o[*2] |-> !reference_clock_o && !interrupt_pin_idle_mode
    && !reference_clock_output_off) else $error("soft reset incomplete");
endmodule // gidc_regs_assertions
bind gidc_regs gidc_regs_assertions i_chk (.*);

// >>> testbench/testbench.sv
// self-checking bench for the id and control register bank
// assumes gidc_regs and its checker are compiled before it
`timescale 1ns/1ns
module testbench;
logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
logic wb_we_i = 1'h0, mii_mode_i = 1'h0, interrupt_active_i = 1'h0;
logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0, sel_mask = 4'hF;
logic [31:0] wb_dat_i = 32'h0, q[$];
wire [31:0] wb_dat_o;
wire wb_ack_o, reference_clock_o, irq_n_o, irq_n_oe_o, datapath_reset_o;
wire reference_clock_output_off, interrupt_pin_idle_mode;
int error_cnt = 0, checks = 0;
bit roll = 0;
// ====
// design, clock, random interrupt source, read monitor
gidc_regs #(.RMII_PRESENT(1'h0), .PHY_PRESENT(1'h1), .LIU_PRESENT(1'h1),
    .SILICON_REVISION(3'h5), .PORT_COUNT_MINUS_ONE(3'h3),
    .IMUX_PRESENT(1'h0)) i_dut (.*);
always #20 clk_i = ~clk_i;
always @(posedge clk_i) if (roll) interrupt_active_i <= 1'($urandom);
always @(posedge clk_i)
    if (wb_ack_o === 1'h1 && !wb_we_i) cmp(q.pop_front(), wb_dat_o);
task cmp(input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
        error_cnt++;
        $display("CHECK FAILED %0t exp %h got %h", $time, e, g);
    end
endtask
task bus(input [3:0] a, input w, input [31:0] d);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_sel_i <= sel_mask;
    @(posedge clk_i);
    while (wb_ack_o !== 1'h1) @(posedge clk_i);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
endtask
task rd(input [3:0] a, input [31:0] e);
    q.push_back(e);
    bus(a, 1'h0, 32'h0);
endtask
task summarize;
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
// ====
// main sequence and watchdog
initial begin
    void'($urandom(43449));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(4'h0, 32'h1D);
    rd(4'h4, 32'h72);
    rd(4'h8, 32'h0);
    bus(4'h0, 1'h1, 32'hFF);
    rd(4'h0, 32'h1D);
    rd(4'hC, 32'h0);
    roll = 1;
    for (int v = 0; v < 8; v += 2) begin
        bus(4'h8, 1'h1, 32'(v));
        rd(4'h8, 32'(v));
        repeat (12) @(posedge clk_i);
    end
    // a control write without byte lane 0 must leave the byte alone
    sel_mask = 4'hE;
    bus(4'h8, 1'h1, 32'h7);
    sel_mask = 4'hF;
    rd(4'h8, 32'h6);
    mii_mode_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    mii_mode_i <= 1'h0;
    bus(4'h8, 1'h1, 32'h7);
    rd(4'h8, 32'h1);
    repeat (3) @(posedge clk_i);
    rd(4'h8, 32'h1);
    cmp(32'(datapath_reset_o), 32'h1);
    bus(4'h8, 1'h1, 32'h0);
    repeat (6) @(posedge clk_i);
    cmp(32'(datapath_reset_o), 32'h0);
    rd(4'h8, 32'h0);
    repeat (12) @(posedge clk_i);
    summarize();
end
initial begin
    #40000;
    error_cnt++;
    summarize();
end
endmodule // testbench
